// [design/txdma_defines.svh]
// offsets, field positions, reset values and counts of the transmit dma block
`ifndef TXDMA_DEFINES_SVH
`define TXDMA_DEFINES_SVH

`define REG_CMD          5'h00
`define REG_TPS          5'h04
`define REG_TBCL         5'h05
`define REG_TBCH         5'h06
`define REG_RSAL         5'h08
`define REG_RSAH         5'h09
`define REG_RBCL         5'h0a
`define REG_RBCH         5'h0b
`define REG_RING         5'h0d
`define REG_DCR          5'h0e
`define REG_MQC          5'h1b
`define REG_TEP          5'h1c
`define REG_RFIRST       5'h1d
`define REG_RLAST        5'h1e

`define CMD_SND_BIT      2
`define CMD_RD_MSB       5
`define CMD_RD_LSB       3
`define RD_WRITE         3'h2
`define RD_ABORT         3'h4
`define STS_DONE_BIT     0
`define STS_COLL_BIT     2
`define STS_ABORT_BIT    3
`define TEP_FULL_BIT     7

`define RST_BYTE         8'h00
`define RST_WORD         16'h0000
`define RST_RING_FIRST   8'h00
`define RST_RING_LAST    8'h0b

`define PRE_BYTE         8'h55
`define SFD_BYTE         8'hd5
`define PRE_LAST         3'h7
`define MIN_FRAME        64
`define FCS_LEN          4
`define MIN_BODY         16'(`MIN_FRAME - `FCS_LEN)
`define RETRY_MAX        4'hf
`define CRC_POLY         32'hedb88320
`define CRC_INIT         32'hffffffff
`define QUEUE_DEPTH      4
`define MEM_WORDS        8192

`endif

// [design/txdma_pkg.sv]
// types shared by the transmit dma block
package txdma_pkg;

  typedef enum logic [5:0] {
    S_IDLE  = 6'b000001,
    S_PREF  = 6'b000010,
    S_PRE   = 6'b000100,
    S_DATA  = 6'b001000,
    S_FCS   = 6'b010000,
    S_DRAIN = 6'b100000
  } tx_state_t;

  typedef logic [23:0] tx_cmd_t;

endpackage

// [design/frame_buffer.sv]
// two-entry byte buffer between the frame builder and the mac
`timescale 1ns/1ps
module frame_buffer (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // filling side
  input  wire logic       in_valid,
  input  wire logic [7:0] in_data,
  output logic            in_ready,
  // draining side
  output logic            out_valid,
  output logic [7:0]      out_data,
  input  wire logic       out_ready,
  // control
  input  wire logic       flush,
  output logic            empty
);

  logic       head_v_reg;
  logic       head_v_next;
  logic       tail_v_reg;
  logic       tail_v_next;
  logic [7:0] head_reg;
  logic [7:0] head_next;
  logic [7:0] tail_reg;
  logic [7:0] tail_next;

  assign in_ready  = ~tail_v_reg;
  assign out_valid = head_v_reg;
  assign out_data  = head_reg;
  assign empty     = ~head_v_reg & ~tail_v_reg;

  always_comb begin
    head_v_next = head_v_reg;
    tail_v_next = tail_v_reg;
    head_next   = head_reg;
    tail_next   = tail_reg;
    if (flush) begin
      head_v_next = 1'b0;
      tail_v_next = 1'b0;
    end else begin
      if (head_v_reg && out_ready) begin
        if (tail_v_reg) begin
          head_next   = tail_reg;
          tail_v_next = 1'b0;
        end else begin
          head_v_next = 1'b0;
        end
      end
      if (in_valid && ~tail_v_reg) begin
        if (!head_v_next) begin
          head_next   = in_data;
          head_v_next = 1'b1;
        end else begin
          tail_next   = in_data;
          tail_v_next = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      head_v_reg <= 1'b0;
      tail_v_reg <= 1'b0;
      head_reg   <= 8'h00;
      tail_reg   <= 8'h00;
    end else begin
      head_v_reg <= head_v_next;
      tail_v_reg <= tail_v_next;
      head_reg   <= head_next;
      tail_reg   <= tail_next;
    end
  end

endmodule

// [design/tx_cmd_queue.sv]
// queue of pending transmit commands: page start and byte count
`timescale 1ns/1ps
`include "txdma_defines.svh"
module tx_cmd_queue
  import txdma_pkg::*;
(
  // clock and reset
  input  wire logic    clk,
  input  wire logic    rst_n,
  // push side
  input  wire logic    push,
  input  tx_cmd_t      push_data,
  output logic         full,
  // pop side
  input  wire logic    pop,
  output tx_cmd_t      pop_data,
  output logic         not_empty
);

  tx_cmd_t    slot [`QUEUE_DEPTH];
  logic [1:0] wr_reg;
  logic [1:0] wr_next;
  logic [1:0] rd_reg;
  logic [1:0] rd_next;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic       do_push;
  logic       do_pop;

  assign full      = (cnt_reg == 3'(`QUEUE_DEPTH));
  assign not_empty = (cnt_reg != 3'h0);
  assign pop_data  = slot[rd_reg];
  assign do_push   = push & ~full;
  assign do_pop    = pop & not_empty;

  always_comb begin
    wr_next  = do_push ? wr_reg + 2'h1 : wr_reg;
    rd_next  = do_pop ? rd_reg + 2'h1 : rd_reg;
    cnt_next = cnt_reg + {2'h0, do_push} - {2'h0, do_pop};
  end

  always_ff @(posedge clk) begin
    if (do_push) begin
      slot[wr_reg] <= push_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg  <= 2'h0;
      rd_reg  <= 2'h0;
      cnt_reg <= 3'h0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

endmodule

// [design/tx_buffer_dma.sv]
// transmit buffer memory, local dma read to the mac, remote dma write
`timescale 1ns/1ps
`include "txdma_defines.svh"
// Overview of operation
// - local dma reads packet bytes for the mac
// - preamble, sync and crc added here
// - ring off: remote address runs on
// - ring on: past last page wraps first
// - with queue enabled, transmit command pushes into queue unless full
// - after completion pop next queued packet
// - end page updated after every packet
// - short frames padded to 64 bytes
// - data port word or byte by select
// - command clears status unless popped as a packet ends, prefetches, awaits gap
// - start needs gap, byte, back-off done
// - collision flushes, restores pointers, counts
// - fifteen retries colliding aborts the packet
// - word mode even byte on low lane
// - byte mode bytes in consecutive order
// - bytes sent in ascending buffer order
// - remote dma by start and count pairs
// - remote write stores, increments, counts down
// - page is a 256 byte block
module tx_buffer_dma
  import txdma_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // host register port
  input  wire logic [4:0]  REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic [7:0]  REG_WDATA,
  output logic      [7:0]  REG_RDATA,
  // host data port
  input  wire logic        DATA_WR,
  input  wire logic [15:0] DATA_WDATA,
  output logic             DATA_READY,
  // mac transmit side
  output logic      [7:0]  MAC_TX_DATA,
  output logic             MAC_TX_VALID,
  input  wire logic        MAC_TX_READY,
  input  wire logic        MAC_IPG_DONE,
  input  wire logic        MAC_BACKOFF_DONE,
  input  wire logic        MAC_COLLISION
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0]  d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic [15:0] next_addr(input logic [15:0] a,
                                            input logic [15:0] step,
                                            input logic        ring,
                                            input logic [7:0]  first,
                                            input logic [7:0]  last);
    logic [15:0] n;
    n = a + step;
    if (ring && (n[15:8] > last)) begin
      n = {first, 8'h00};
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [15:0] mem [`MEM_WORDS];

  logic [7:0]  tps_reg, tps_next;
  logic [15:0] tbc_reg, tbc_next;
  logic [15:0] rsa_reg, rsa_next;
  logic [15:0] rbc_reg, rbc_next;
  logic        rwr_reg, rwr_next;
  logic        wrd_reg, wrd_next;
  logic        ring_reg, ring_next;
  logic [7:0]  first_reg, first_next;
  logic [7:0]  last_reg, last_next;
  logic        qen_reg, qen_next;
  logic [7:0]  rdata_reg, rdata_next;

  tx_state_t   st_reg, st_next;
  logic [13:0] ptr_reg, ptr_next;
  logic [7:0]  sp_reg, sp_next;
  logic [15:0] len_reg, len_next;
  logic [15:0] rem_reg, rem_next;
  logic [15:0] sent_reg, sent_next;
  logic [2:0]  pc_reg, pc_next;
  logic [31:0] crc_reg, crc_next;
  logic [1:0]  ci_reg, ci_next;
  logic [3:0]  rt_reg, rt_next;
  logic        pf_reg, pf_next;
  logic [7:0]  sts_reg, sts_next;
  logic [7:0]  col_reg, col_next;
  logic [7:0]  tep_reg, tep_next;

  logic        snd_wr;
  logic        dwr;
  logic [15:0] step;
  logic [15:0] word;
  logic [7:0]  mem_byte;
  logic [13:0] last_ptr;
  logic [31:0] fcs;
  logic        buf_in_valid;
  logic [7:0]  buf_in_data;
  logic        buf_in_ready;
  logic        buf_flush;
  logic        buf_empty;
  logic        q_pop;
  logic        q_full;
  logic        q_valid;
  tx_cmd_t     q_data;
  logic        coll;
  logic        finish;
  logic        abort;
  logic        done;
  logic        load;
  logic [7:0]  ld_page;
  logic [15:0] ld_len;

  ////////////////////////////////////////////////////////////////////////////
  // helpers and submodules

  assign snd_wr   = REG_WR && (REG_ADDR == `REG_CMD)
                    && REG_WDATA[`CMD_SND_BIT];
  assign dwr      = DATA_WR && rwr_reg;
  assign step     = wrd_reg ? 16'h0002 : 16'h0001;
  assign word     = mem[ptr_reg[13:1]];
  assign mem_byte = ptr_reg[0] ? word[15:8] : word[7:0];
  // last payload byte of the packet, also right after an abort
  assign last_ptr = {sp_reg[5:0], 8'h00} + len_reg[13:0] - 14'h0001;
  assign fcs      = ~crc_reg;

  frame_buffer u_buf (
    .clk       (CLK),
    .rst_n     (RST_N),
    .in_valid  (buf_in_valid),
    .in_data   (buf_in_data),
    .in_ready  (buf_in_ready),
    .out_valid (MAC_TX_VALID),
    .out_data  (MAC_TX_DATA),
    .out_ready (MAC_TX_READY),
    .flush     (buf_flush),
    .empty     (buf_empty)
  );

  tx_cmd_queue u_queue (
    .clk       (CLK),
    .rst_n     (RST_N),
    .push      (snd_wr && qen_reg),
    .push_data ({tps_reg, tbc_reg}),
    .full      (q_full),
    .pop       (q_pop),
    .pop_data  (q_data),
    .not_empty (q_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register port and remote dma write

  always_comb begin
    tps_next   = tps_reg;
    tbc_next   = tbc_reg;
    rsa_next   = rsa_reg;
    rbc_next   = rbc_reg;
    rwr_next   = rwr_reg;
    wrd_next   = wrd_reg;
    ring_next  = ring_reg;
    first_next = first_reg;
    last_next  = last_reg;
    qen_next   = qen_reg;
    if (rwr_reg && (rbc_reg == 16'h0000)) begin
      rwr_next = 1'b0;
    end
    if (REG_WR) begin
      unique case (REG_ADDR)
        `REG_CMD: begin
          if (REG_WDATA[`CMD_RD_MSB:`CMD_RD_LSB] == `RD_WRITE) begin
            rwr_next = 1'b1;
          end else if (REG_WDATA[`CMD_RD_MSB:`CMD_RD_LSB] == `RD_ABORT) begin
            rwr_next = 1'b0;
          end
        end
        `REG_TPS:    tps_next = REG_WDATA;
        `REG_TBCL:   tbc_next[7:0] = REG_WDATA;
        `REG_TBCH:   tbc_next[15:8] = REG_WDATA;
        `REG_RSAL:   rsa_next[7:0] = REG_WDATA;
        `REG_RSAH:   rsa_next[15:8] = REG_WDATA;
        `REG_RBCL:   rbc_next[7:0] = REG_WDATA;
        `REG_RBCH:   rbc_next[15:8] = REG_WDATA;
        `REG_RING:   ring_next = REG_WDATA[0];
        `REG_DCR:    wrd_next = REG_WDATA[0];
        `REG_MQC:    qen_next = REG_WDATA[0];
        `REG_RFIRST: first_next = REG_WDATA;
        `REG_RLAST:  last_next = REG_WDATA;
        default: begin
        end
      endcase
    end
    if (dwr) begin
      rsa_next = next_addr(rsa_reg, step, ring_reg, first_reg, last_reg);
      if (rbc_reg <= step) begin
        rbc_next = 16'h0000;
        rwr_next = 1'b0;
      end else begin
        rbc_next = rbc_reg - step;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (dwr) begin
      if (wrd_reg) begin
        mem[rsa_reg[13:1]] <= DATA_WDATA;
      end else if (rsa_reg[0]) begin
        mem[rsa_reg[13:1]][15:8] <= DATA_WDATA[7:0];
      end else begin
        mem[rsa_reg[13:1]][7:0] <= DATA_WDATA[7:0];
      end
    end
  end

  always_comb begin
    unique case (REG_ADDR)
      `REG_CMD:    rdata_next = {2'h0, rwr_reg ? `RD_WRITE : `RD_ABORT,
                                 st_reg != S_IDLE, 2'h0};
      `REG_TPS:    rdata_next = sts_reg;
      `REG_TBCL:   rdata_next = col_reg;
      `REG_RSAL:   rdata_next = rsa_reg[7:0];
      `REG_RSAH:   rdata_next = rsa_reg[15:8];
      `REG_RBCL:   rdata_next = rbc_reg[7:0];
      `REG_RBCH:   rdata_next = rbc_reg[15:8];
      `REG_RING:   rdata_next = {7'h00, ring_reg};
      `REG_DCR:    rdata_next = {7'h00, wrd_reg};
      `REG_MQC:    rdata_next = {7'h00, qen_reg};
      `REG_TEP:    rdata_next = {q_full, tep_reg[6:0]};
      `REG_RFIRST: rdata_next = first_reg;
      `REG_RLAST:  rdata_next = last_reg;
      default:     rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tps_reg   <= `RST_BYTE;
      tbc_reg   <= `RST_WORD;
      rsa_reg   <= `RST_WORD;
      rbc_reg   <= `RST_WORD;
      rwr_reg   <= 1'b0;
      wrd_reg   <= 1'b0;
      ring_reg  <= 1'b0;
      first_reg <= `RST_RING_FIRST;
      last_reg  <= `RST_RING_LAST;
      qen_reg   <= 1'b0;
      rdata_reg <= `RST_BYTE;
    end else begin
      tps_reg   <= tps_next;
      tbc_reg   <= tbc_next;
      rsa_reg   <= rsa_next;
      rbc_reg   <= rbc_next;
      rwr_reg   <= rwr_next;
      wrd_reg   <= wrd_next;
      ring_reg  <= ring_next;
      first_reg <= first_next;
      last_reg  <= last_next;
      qen_reg   <= qen_next;
      rdata_reg <= rdata_next;
    end
  end

  assign REG_RDATA  = rdata_reg;
  assign DATA_READY = rwr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // transmit sequencer

  always_comb begin
    st_next      = st_reg;
    ptr_next     = ptr_reg;
    sp_next      = sp_reg;
    len_next     = len_reg;
    rem_next     = rem_reg;
    sent_next    = sent_reg;
    pc_next      = pc_reg;
    crc_next     = crc_reg;
    ci_next      = ci_reg;
    rt_next      = rt_reg;
    pf_next      = pf_reg;
    sts_next     = sts_reg;
    col_next     = col_reg;
    tep_next     = tep_reg;
    buf_in_valid = 1'b0;
    buf_in_data  = 8'h00;
    buf_flush    = 1'b0;
    q_pop        = 1'b0;
    finish       = 1'b0;
    abort        = 1'b0;
    load         = 1'b0;
    ld_page      = tps_reg;
    ld_len       = tbc_reg;
    coll         = MAC_COLLISION && (st_reg != S_IDLE) && (st_reg != S_PREF);
    unique case (st_reg)
      S_IDLE: begin
        if (qen_reg && q_valid) begin
          load = 1'b1;
        end else if (!qen_reg && snd_wr) begin
          load = 1'b1;
        end
      end
      S_PREF: begin
        pf_next = 1'b1;
        if (pf_reg && MAC_IPG_DONE && MAC_BACKOFF_DONE) begin
          st_next = S_PRE;
          pc_next = 3'h0;
        end
      end
      S_PRE: begin
        buf_in_valid = 1'b1;
        buf_in_data  = (pc_reg == `PRE_LAST) ? `SFD_BYTE : `PRE_BYTE;
        if (buf_in_ready) begin
          pc_next = pc_reg + 3'h1;
          if (pc_reg == `PRE_LAST) begin
            st_next = S_DATA;
          end
        end
      end
      S_DATA: begin
        buf_in_valid = 1'b1;
        buf_in_data  = (rem_reg != 16'h0000) ? mem_byte : 8'h00;
        if (buf_in_ready) begin
          crc_next  = crc_byte(crc_reg, buf_in_data);
          sent_next = sent_reg + 16'h0001;
          if (rem_reg != 16'h0000) begin
            rem_next = rem_reg - 16'h0001;
            ptr_next = ptr_reg + 14'h0001;
          end
          if ((rem_reg <= 16'h0001) && (sent_next >= `MIN_BODY)) begin
            st_next = S_FCS;
            ci_next = 2'h0;
          end
        end
      end
      S_FCS: begin
        buf_in_valid = 1'b1;
        buf_in_data  = 8'(fcs >> {ci_reg, 3'h0});
        if (buf_in_ready) begin
          ci_next = ci_reg + 2'h1;
          if (ci_reg == 2'h3) begin
            st_next = S_DRAIN;
          end
        end
      end
      S_DRAIN: begin
        finish = buf_empty && !coll;
      end
      default: begin
        st_next = S_IDLE;
      end
    endcase
    if (coll) begin
      buf_flush    = 1'b1;
      buf_in_valid = 1'b0;
      sts_next[`STS_COLL_BIT] = 1'b1;
      col_next     = col_reg + 8'h01;
      ptr_next     = {sp_reg[5:0], 8'h00};
      rem_next     = len_reg;
      sent_next    = 16'h0000;
      crc_next     = `CRC_INIT;
      pf_next      = 1'b0;
      if (rt_reg == `RETRY_MAX) begin
        abort = 1'b1;
        sts_next[`STS_ABORT_BIT] = 1'b1;
      end else begin
        rt_next = rt_reg + 4'h1;
        st_next = S_PREF;
      end
    end
    done = finish || abort;
    if (finish) begin
      sts_next[`STS_DONE_BIT] = 1'b1;
    end
    if (done) begin
      tep_next = {2'h0, last_ptr[13:8]};
      st_next  = S_IDLE;
      if (qen_reg && q_valid) begin
        load = 1'b1;
      end
    end
    if (load) begin
      if (qen_reg) begin
        q_pop   = 1'b1;
        ld_page = q_data[23:16];
        ld_len  = q_data[15:0];
      end
      if (!done) begin
        sts_next = 8'h00;
      end
      sp_next   = ld_page;
      len_next  = ld_len;
      rem_next  = ld_len;
      ptr_next  = {ld_page[5:0], 8'h00};
      sent_next = 16'h0000;
      crc_next  = `CRC_INIT;
      rt_next   = 4'h0;
      pf_next   = 1'b0;
      st_next   = S_PREF;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg   <= S_IDLE;
      ptr_reg  <= 14'h0000;
      sp_reg   <= `RST_BYTE;
      len_reg  <= `RST_WORD;
      rem_reg  <= `RST_WORD;
      sent_reg <= `RST_WORD;
      pc_reg   <= 3'h0;
      crc_reg  <= `CRC_INIT;
      ci_reg   <= 2'h0;
      rt_reg   <= 4'h0;
      pf_reg   <= 1'b0;
      sts_reg  <= `RST_BYTE;
      col_reg  <= `RST_BYTE;
      tep_reg  <= `RST_BYTE;
    end else begin
      st_reg   <= st_next;
      ptr_reg  <= ptr_next;
      sp_reg   <= sp_next;
      len_reg  <= len_next;
      rem_reg  <= rem_next;
      sent_reg <= sent_next;
      pc_reg   <= pc_next;
      crc_reg  <= crc_next;
      ci_reg   <= ci_next;
      rt_reg   <= rt_next;
      pf_reg   <= pf_next;
      sts_reg  <= sts_next;
      col_reg  <= col_next;
      tep_reg  <= tep_next;
    end
  end

endmodule

// [verification/tx_dma_checker_sva.sv]
// concurrent checks on the transmit dma block ports
`timescale 1ns/1ps
`include "txdma_defines.svh"
module tx_dma_checker (
  // clock and reset
  input wire logic       CLK,
  input wire logic       RST_N,
  // host side
  input wire logic [4:0] REG_ADDR,
  input wire logic       REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic       DATA_READY,
  // mac side
  input wire logic [7:0] MAC_TX_DATA,
  input wire logic       MAC_TX_VALID,
  input wire logic       MAC_TX_READY,
  input wire logic       MAC_IPG_DONE,
  input wire logic       MAC_COLLISION
);
  wire start_w = REG_WR && REG_ADDR == `REG_CMD &&
                 REG_WDATA[5:3] == `RD_WRITE;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence abort_cmd;
    REG_WR && REG_ADDR == `REG_CMD && REG_WDATA[5:3] == `RD_ABORT;
  endsequence
  sequence stalled;
    MAC_TX_VALID && !MAC_TX_READY && !MAC_COLLISION;
  endsequence
  property select_back;
    logic v;
    (REG_WR && REG_ADDR == `REG_DCR, v = REG_WDATA[0]) ##1
      (!REG_WR && REG_ADDR == `REG_DCR) |=> REG_RDATA[0] == v;
  endproperty
  unmapped_read_a: assert property (REG_ADDR == 5'h1f |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  select_back_a: assert property (select_back)
    else $error("word select readback wrong");
  end_page_a: assert property (REG_ADDR == `REG_TEP |=> !REG_RDATA[6])
    else $error("end page bit 6 set");
  rw_start_a: assert property (!DATA_READY && !start_w |=> !DATA_READY)
    else $error("data port ready without start");
  rw_abort_a: assert property (abort_cmd |=> !DATA_READY)
    else $error("remote abort ignored");
  stall_hold_a: assert property (stalled |=> MAC_TX_VALID && $stable(MAC_TX_DATA))
    else $error("stalled byte not held");
  gap_wait_a: assert property (!MAC_IPG_DONE [*3] |->
      !($rose(MAC_TX_VALID) && MAC_TX_DATA == `PRE_BYTE))
    else $error("frame started inside gap");
  coll_flush_a: assert property (MAC_COLLISION && MAC_TX_VALID |=> !MAC_TX_VALID)
    else $error("buffer not flushed on collision");
endmodule

bind tx_buffer_dma tx_dma_checker chk (.CLK(CLK), .RST_N(RST_N),
  .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
  .REG_RDATA(REG_RDATA), .DATA_READY(DATA_READY),
  .MAC_TX_DATA(MAC_TX_DATA), .MAC_TX_VALID(MAC_TX_VALID),
  .MAC_TX_READY(MAC_TX_READY), .MAC_IPG_DONE(MAC_IPG_DONE),
  .MAC_COLLISION(MAC_COLLISION));

// [verification/mac_model.sv]
// behavioural mac at the far side of the transmit stream
`timescale 1ns/1ps
module mac_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // stream from the block
  input  wire logic        valid,
  // collision plan from the bench
  input  wire logic [31:0] coll_at,
  input  wire logic [31:0] coll_max,
  // status towards the block
  output logic             ready,
  output logic             ipg_done,
  output logic             backoff_done,
  output logic             collision
);
  int cnt, ncoll, gap, boff;
  assign ipg_done = gap == 0;
  assign backoff_done = boff == 0;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready <= 1'b0;
      collision <= 1'b0;
      {cnt, ncoll, gap, boff} <= '0;
    end else begin
      collision <= 1'b0;
      ready <= ($urandom % 4) != 0;
      gap <= (valid && ready) ? 4 : (gap > 0 ? gap - 1 : 0);
      boff <= boff > 0 ? boff - 1 : 0;
      if (coll_max == 0) begin
        cnt <= 0;
        ncoll <= 0;
      end else if (valid && ready) begin
        cnt <= cnt + 1;
      end
      // collide on demand, refuse the byte and start a back-off
      if (coll_max != 0 && ncoll < coll_max && valid && cnt == coll_at) begin
        collision <= 1'b1;
        ready <= 1'b0;
        cnt <= 0;
        ncoll <= ncoll + 1;
        boff <= 6;
      end
    end
  end
endmodule

// [verification/tx_buffer_dma_tb_top.sv]
// self-checking bench of the transmit dma block
`timescale 1ns/1ps
`include "txdma_defines.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
`define WAITF(c) begin for (int t = 0; t < 5000 && !(c); t++) begin \
  @(posedge CLK); #1; end if (!(c)) begin n_fail++; end_of_test(); end end
module tx_buffer_dma_tb_top;
  logic        CLK = 0, RST_N = 0, REG_WR = 0, DATA_WR = 0, ign = 0;
  logic [4:0]  REG_ADDR = 0;
  logic [7:0]  REG_WDATA = 0, REG_RDATA, MAC_TX_DATA, r;
  logic [15:0] DATA_WDATA = 0;
  logic        DATA_READY, MAC_TX_VALID, MAC_TX_READY;
  logic        MAC_IPG_DONE, MAC_BACKOFF_DONE, MAC_COLLISION;
  logic [7:0]  mem [16384];
  logic [7:0]  exp_q [$];
  int          n_fail = 0, cmp_count = 0, coll_at = 0, coll_max = 0;
  always #10 CLK = ~CLK;
  tx_buffer_dma dut (.CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .DATA_WR(DATA_WR), .DATA_WDATA(DATA_WDATA), .DATA_READY(DATA_READY),
    .MAC_TX_DATA(MAC_TX_DATA), .MAC_TX_VALID(MAC_TX_VALID),
    .MAC_TX_READY(MAC_TX_READY), .MAC_IPG_DONE(MAC_IPG_DONE),
    .MAC_BACKOFF_DONE(MAC_BACKOFF_DONE), .MAC_COLLISION(MAC_COLLISION));
  mac_model mac (.clk(CLK), .rst_n(RST_N), .valid(MAC_TX_VALID),
    .coll_at(coll_at), .coll_max(coll_max), .ready(MAC_TX_READY),
    .ipg_done(MAC_IPG_DONE), .backoff_done(MAC_BACKOFF_DONE),
    .collision(MAC_COLLISION));
  task end_of_test;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WR <= 1'b1;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask
  task chk(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge CLK);
    REG_ADDR <= a;
    @(posedge CLK);
    #1 r = REG_RDATA;
    `CHK(r & m, e)
  endtask
  task fill(input int a, input int n, input logic w);
    wr(`REG_RSAL, a[7:0]);
    wr(`REG_RSAH, a[15:8]);
    wr(`REG_RBCL, n[7:0]);
    wr(`REG_RBCH, n[15:8]);
    wr(`REG_DCR, {7'h00, w});
    for (int i = 0; i < n + 1; i++) mem[(a + i) % 16384] = 8'($urandom);
    wr(`REG_CMD, 8'h12);
    `WAITF(DATA_READY)
    for (int i = 0; i < n; i += w ? 2 : 1) begin
      @(posedge CLK);
      DATA_WR <= 1'b1;
      DATA_WDATA <= {mem[(a + i + 1) % 16384], mem[(a + i) % 16384]};
    end
    @(posedge CLK);
    DATA_WR <= 1'b0;
  endtask
  // frame as the wire must see it: preamble, payload, pad, inverted crc
  task send(input int p, input int n);
    logic [31:0] crc;
    logic [7:0]  b;
    crc = `CRC_INIT;
    repeat (7) exp_q.push_back(`PRE_BYTE);
    exp_q.push_back(`SFD_BYTE);
    for (int i = 0; i < n || i < 60; i++) begin
      b = (i < n) ? mem[(p * 256 + i) % 16384] : 8'h00;
      exp_q.push_back(b);
      for (int k = 0; k < 8; k++)
        crc = (crc >> 1) ^ ((crc[0] ^ b[k]) ? `CRC_POLY : 32'h0);
    end
    for (int k = 0; k < 4; k++) exp_q.push_back(~crc[8 * k +: 8]);
    wr(`REG_TPS, p[7:0]);
    wr(`REG_TBCL, n[7:0]);
    wr(`REG_TBCH, n[15:8]);
    wr(`REG_CMD, 8'h04);
  endtask
  task done(input int p, input int n, input logic [7:0] st);
    int e;
    e = (p * 256 + n - 1) >> 8;
    `WAITF(exp_q.size() == 0)
    for (int t = 0; t < 500 && (r & st) !== st; t++)
      chk(`REG_TPS, 8'h00, 8'h00);
    chk(`REG_TPS, 8'h0d, st);
    chk(`REG_TEP, 8'hff, {2'b00, e[5:0]});
  endtask
  always @(posedge CLK) begin
    if (MAC_TX_VALID && MAC_TX_READY && !ign) begin
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
      else `CHK(MAC_TX_DATA, exp_q.pop_front())
    end
  end
  initial begin
    r = 8'($urandom(36558));
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    chk(`REG_RFIRST, 8'hff, `RST_RING_FIRST);
    chk(`REG_RLAST, 8'hff, `RST_RING_LAST);
    chk(5'h1f, 8'hff, 8'h00);
    fill(16'h4000, 20, 1'b0);
    send(8'h40, 20);
    done(8'h40, 20, 8'h01);
    fill(16'h4100, 300, 1'b1);
    send(8'h41, 300);
    done(8'h41, 300, 8'h01);
    fill(16'h4400, 40, 1'b1);
    coll_at <= 5;
    coll_max <= 1;
    send(8'h44, 40);
    `WAITF(MAC_COLLISION)
    exp_q.delete();
    send(8'h44, 40);
    done(8'h44, 40, 8'h05);
    chk(`REG_TBCL, 8'hff, 8'h01);
    // clears the model's byte count before the next collision plan
    coll_max = 0;
    fill(16'h4600, 30, 1'b0);
    ign <= 1'b1;
    coll_at <= 3;
    coll_max <= 16;
    send(8'h46, 30);
    exp_q.delete();
    done(8'h46, 30, 8'h0c);
    `CHK(mac.ncoll, 16)
    ign = 1'b0;
    coll_max = 0;
    wr(`REG_MQC, 8'h01);
    fill(16'h4800, 30, 1'b1);
    fill(16'h4900, 70, 1'b1);
    chk(`REG_TEP, 8'h80, 8'h00);
    send(8'h48, 30);
    send(8'h49, 70);
    done(8'h49, 70, 8'h01);
    wr(`REG_MQC, 8'h00);
    wr(`REG_RFIRST, 8'h50);
    wr(`REG_RLAST, 8'h50);
    wr(`REG_RING, 8'h01);
    fill(16'h50fe, 4, 1'b1);
    chk(`REG_RSAH, 8'hff, 8'h50);
    chk(`REG_RSAL, 8'hff, 8'h02);
    chk(`REG_RBCL, 8'hff, 8'h00);
    wr(`REG_RING, 8'h00);
    fill(16'h50fe, 4, 1'b1);
    chk(`REG_RSAH, 8'hff, 8'h51);
    wr(`REG_RBCL, 8'h0a);
    wr(`REG_CMD, 8'h12);
    `WAITF(DATA_READY)
    wr(`REG_CMD, 8'h22);
    `WAITF(!DATA_READY)
    `CHK(DATA_READY, 1'b0)
    end_of_test();
  end
endmodule
